/* File: design/capm_top.sv */
// Current average pulse monitor with its APB register file.
//
// Our own choices: register access over APB and the register addresses.
`include "capm_params.svh"

module capm_top #(
  parameter int unsigned TICK_CYCLES = `CAPM_TICK_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire capm_pkg::capm_drive_t drive,
  input  wire logic [15:0]          maintenance_hours_count,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      avg_current_pulse_out
);

  capm_pkg::capm_state_t state;
  logic                  tick;
  logic [7:0]            phase_cnt;
  logic [7:0]            end_len;
  logic                  invalid;
  logic                  wait_new_const;
  logic [19:0]           sample_sum;
  logic [3:0]            sample_cnt;
  logic                  den_zero;
  logic                  div_start;
  logic [25:0]           div_q;
  logic                  div_busy;
  logic [7:0]            low_w;
  logic [7:0]            maint_w;
  logic [7:0]            next_maint_w;
  logic [15:0]           current_averaging_window;
  logic [15:0]           transient_mask_interval;
  logic [15:0]           reference_current_setting;
  logic [15:0]           restart_coast_setting;
  logic [15:0]           extended_display_select;
  logic [15:0]           param_write_select;
  logic [15:0]           user_scratch_one;
  logic [15:0]           user_scratch_two;
  logic                  restart_en;
  logic                  wr_en;
  logic [15:0]           wdata16;
  logic [31:0]           status_word;

  function automatic logic fits(input logic [15:0] value,
                                input logic [15:0] limit);
    fits = (value <= limit);
  endfunction

  function automatic logic [7:0] clamp8(input logic [25:0] value,
                                        input logic [7:0]  lo,
                                        input logic [7:0]  hi);
    if (value < {18'h00000, lo}) begin
      clamp8 = lo;
    end else if (value > {18'h00000, hi}) begin
      clamp8 = hi;
    end else begin
      clamp8 = value[7:0];
    end
  endfunction

  // Every pulse duration below is counted in these 0.1 s ticks.
  capm_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .tick  (tick)
  );

  // The quotient is sum*50/(samples*ref), so 100 % of reference gives 5 s.
  capm_div u_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .start    (div_start),
    .num      (26'(sample_sum) * `CAPM_LOW_SCALE),
    .den      (16'(sample_cnt) * reference_current_setting[15:0]),
    .quotient (div_q),
    .busy     (div_busy)
  );

  assign restart_en = (restart_coast_setting != `CAPM_RESTART_DISABLED);
  assign wr_en      = psel && penable && pready && pwrite && !pslverr;
  assign wdata16    = pwdata[15:0];

  // Ten-percent and 180-percent points land exactly on the clamp limits.
  assign low_w = den_zero ? `CAPM_LOW_MAX_TICKS :
                 clamp8(div_q, `CAPM_LOW_MIN_TICKS, `CAPM_LOW_MAX_TICKS);
  // Hours/40000*50 ticks with hours in 100 h units reduces to count/8.
  assign next_maint_w = clamp8(26'(maintenance_hours_count >> `CAPM_MAINT_SHIFT),
                               `CAPM_MAINT_MIN_TICKS,
                               `CAPM_MAINT_MAX_TICKS);

  assign status_word = {1'b0, maint_w[6:0], 1'b0, low_w[6:0], 7'h00,
                        invalid, avg_current_pulse_out, state};

  // Pulse sequencer: one state per segment of the 20 s output cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state                 <= capm_pkg::CAPM_IDLE;
      phase_cnt             <= 8'h00;
      end_len               <= 8'h00;
      invalid               <= 1'b0;
      wait_new_const        <= 1'b0;
      avg_current_pulse_out <= 1'b0;
      maint_w               <= `CAPM_MAINT_MIN_TICKS;
    end else if (ce && tick) begin
      case (state)
        capm_pkg::CAPM_IDLE: begin
          avg_current_pulse_out <= 1'b0;
          phase_cnt             <= 8'h00;
          if (wait_new_const) begin
            if (!drive.const_speed || drive.accel_decel) begin
              wait_new_const <= 1'b0;
            end
          end else if (drive.const_speed && !drive.accel_decel) begin
            state <= capm_pkg::CAPM_MASK;
          end
        end
        capm_pkg::CAPM_MASK: begin
          if (drive.accel_decel || !drive.const_speed) begin
            state <= capm_pkg::CAPM_IDLE;
          end else if (16'(phase_cnt) >= transient_mask_interval) begin
            phase_cnt <= 8'h00;
            if (restart_en && drive.restart_active) begin
              state <= capm_pkg::CAPM_BLANK;
            end else begin
              state                 <= capm_pkg::CAPM_START;
              avg_current_pulse_out <= 1'b1;
              invalid               <= 1'b0;
            end
          end else begin
            phase_cnt <= phase_cnt + 8'h01;
          end
        end
        capm_pkg::CAPM_START: begin
          phase_cnt <= phase_cnt + 8'h01;
          if (drive.accel_decel || !drive.const_speed) begin
            invalid <= 1'b1;
          end
          if (invalid && phase_cnt + 8'h01 == `CAPM_INV_START_TICKS) begin
            state                 <= capm_pkg::CAPM_END;
            end_len               <= `CAPM_INV_END_TICKS;
            phase_cnt             <= 8'h00;
            avg_current_pulse_out <= 1'b0;
          end else if (!invalid && !drive.accel_decel &&
                       drive.const_speed &&
                       phase_cnt + 8'h01 == `CAPM_START_TICKS) begin
            state                 <= capm_pkg::CAPM_LOW;
            maint_w               <= next_maint_w;
            phase_cnt             <= 8'h00;
            avg_current_pulse_out <= 1'b0;
          end
        end
        capm_pkg::CAPM_LOW: begin
          phase_cnt <= phase_cnt + 8'h01;
          if (phase_cnt + 8'h01 == low_w) begin
            state                 <= capm_pkg::CAPM_MAINT;
            phase_cnt             <= 8'h00;
            avg_current_pulse_out <= 1'b1;
          end
        end
        capm_pkg::CAPM_MAINT: begin
          phase_cnt <= phase_cnt + 8'h01;
          if (phase_cnt + 8'h01 == maint_w) begin
            state                 <= capm_pkg::CAPM_END;
            end_len               <= `CAPM_CYCLE_TICKS - `CAPM_START_TICKS -
                                     low_w - maint_w;
            phase_cnt             <= 8'h00;
            avg_current_pulse_out <= 1'b0;
          end
        end
        capm_pkg::CAPM_END, capm_pkg::CAPM_BLANK: begin
          avg_current_pulse_out <= 1'b0;
          phase_cnt             <= phase_cnt + 8'h01;
          // The cycle is never cut short, whatever the drive does.
          if ((state == capm_pkg::CAPM_END &&
               phase_cnt + 8'h01 == end_len) ||
              (state == capm_pkg::CAPM_BLANK &&
               phase_cnt + 8'h01 == `CAPM_CYCLE_TICKS)) begin
            phase_cnt <= 8'h00;
            invalid   <= 1'b0;
            if (drive.out_current == 16'h0000) begin
              state          <= capm_pkg::CAPM_IDLE;
              wait_new_const <= 1'b1;
            end else if (state == capm_pkg::CAPM_BLANK &&
                         (drive.accel_decel || !drive.const_speed)) begin
              // A blank cycle is not repeated on a drive change; a new mask waits instead.
              state <= capm_pkg::CAPM_IDLE;
            end else if (drive.accel_decel) begin
              state <= capm_pkg::CAPM_BLANK;
            end else if (restart_en && drive.restart_active) begin
              state <= capm_pkg::CAPM_BLANK;
            end else if (drive.const_speed) begin
              state                 <= capm_pkg::CAPM_START;
              avg_current_pulse_out <= 1'b1;
            end else begin
              state <= capm_pkg::CAPM_IDLE;
            end
          end
        end
        default: begin
          state <= capm_pkg::CAPM_IDLE;
        end
      endcase
    end
  end

  // Averaging runs over the first window ticks of each start pulse.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_sum <= 20'h00000;
      sample_cnt <= 4'h0;
      div_start  <= 1'b0;
      den_zero   <= 1'b1;
    end else if (ce) begin
      div_start <= 1'b0;
      if (tick && state != capm_pkg::CAPM_START) begin
        sample_sum <= 20'h00000;
        sample_cnt <= 4'h0;
      end else if (tick && !drive.accel_decel &&
                   16'(sample_cnt) < current_averaging_window) begin
        sample_sum <= sample_sum + 20'(drive.out_current);
        sample_cnt <= sample_cnt + 4'h1;
      end
      if (tick && state == capm_pkg::CAPM_START &&
          phase_cnt + 8'h01 == `CAPM_START_TICKS) begin
        // Divider finishes within 27 clocks, long before the low phase ends.
        div_start <= 1'b1;
        den_zero  <= (sample_cnt == 4'h0) ||
                     (reference_current_setting == 16'h0000);
      end
    end
  end

  // APB slave: pready rises one clock into the access phase.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
        if (paddr == `CAPM_OFF_AVG_WINDOW) begin
          prdata <= {16'h0000, current_averaging_window};
        end else if (paddr == `CAPM_OFF_MASK_INTERVAL) begin
          prdata <= {16'h0000, transient_mask_interval};
        end else if (paddr == `CAPM_OFF_REF_CURRENT) begin
          prdata <= {16'h0000, reference_current_setting};
        end else if (paddr == `CAPM_OFF_RESTART_COAST) begin
          prdata <= {16'h0000, restart_coast_setting};
        end else if (paddr == `CAPM_OFF_EXT_DISPLAY) begin
          prdata <= {16'h0000, extended_display_select};
        end else if (paddr == `CAPM_OFF_PARAM_WRITE) begin
          prdata <= {16'h0000, param_write_select};
        end else if (paddr == `CAPM_OFF_SCRATCH_ONE) begin
          prdata <= {16'h0000, user_scratch_one};
        end else if (paddr == `CAPM_OFF_SCRATCH_TWO) begin
          prdata <= {16'h0000, user_scratch_two};
        end else if (paddr == `CAPM_OFF_STATUS) begin
          prdata <= status_word;
        end else begin
          pslverr <= 1'b1;
        end
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Settings; out-of-range writes are dropped and keep the old value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      current_averaging_window  <= `CAPM_RST_AVG_WINDOW;
      transient_mask_interval   <= `CAPM_RST_MASK_INTERVAL;
      reference_current_setting <= `CAPM_RST_REF_CURRENT;
      restart_coast_setting     <= `CAPM_RST_RESTART_COAST;
      extended_display_select   <= `CAPM_RST_EXT_DISPLAY;
      param_write_select        <= `CAPM_RST_PARAM_WRITE;
    end else if (ce && wr_en) begin
      if (paddr == `CAPM_OFF_AVG_WINDOW) begin
        if (wdata16 != 16'h0000 && fits(wdata16, `CAPM_MAX_AVG_WINDOW)) begin
          current_averaging_window <= wdata16;
        end
      end else if (paddr == `CAPM_OFF_MASK_INTERVAL) begin
        if (fits(wdata16, `CAPM_MAX_MASK_INTERVAL)) begin
          transient_mask_interval <= wdata16;
        end
      end else if (paddr == `CAPM_OFF_REF_CURRENT) begin
        if (fits(wdata16, `CAPM_MAX_REF_CURRENT)) begin
          reference_current_setting <= wdata16;
        end
      end else if (paddr == `CAPM_OFF_RESTART_COAST) begin
        if (fits(wdata16, `CAPM_MAX_SETTING)) begin
          restart_coast_setting <= wdata16;
        end
      end else if (paddr == `CAPM_OFF_EXT_DISPLAY) begin
        extended_display_select <= wdata16;
      end else if (paddr == `CAPM_OFF_PARAM_WRITE) begin
        param_write_select <= wdata16;
      end
    end
  end

  // Scratch values feed nothing but the read mux.
  // Keeping them across power loss is the job of the external store.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      user_scratch_one <= `CAPM_RST_SCRATCH;
      user_scratch_two <= `CAPM_RST_SCRATCH;
    end else if (ce && wr_en && extended_display_select == 16'h0000 &&
                 fits(wdata16, `CAPM_MAX_SETTING)) begin
      // Accepted whatever param_write_select holds or the drive does.
      if (paddr == `CAPM_OFF_SCRATCH_ONE) begin
        user_scratch_one <= wdata16;
      end else if (paddr == `CAPM_OFF_SCRATCH_TWO) begin
        user_scratch_two <= wdata16;
      end
    end
  end

endmodule

/* File: design/capm_params.svh */
// Offsets, field positions, reset values and timing counts of the monitor.
`ifndef CAPM_PARAMS_SVH
`define CAPM_PARAMS_SVH

`define CAPM_CLK_PERIOD_NS     10
`define CAPM_TICK_PERIOD_NS    100000000
`define CAPM_TICK_CYCLES       (`CAPM_TICK_PERIOD_NS / `CAPM_CLK_PERIOD_NS)

`define CAPM_CYCLE_TICKS       8'hc8
`define CAPM_START_TICKS       8'h0a
`define CAPM_INV_START_TICKS   8'h23
`define CAPM_INV_END_TICKS     8'ha5
`define CAPM_LOW_MIN_TICKS     8'h05
`define CAPM_LOW_MAX_TICKS     8'h5a
`define CAPM_MAINT_MIN_TICKS   8'h14
`define CAPM_MAINT_MAX_TICKS   8'h5a
`define CAPM_LOW_SCALE         26'h0000032
`define CAPM_MAINT_SHIFT       3

`define CAPM_OFF_AVG_WINDOW    8'h00
`define CAPM_OFF_MASK_INTERVAL 8'h04
`define CAPM_OFF_REF_CURRENT   8'h08
`define CAPM_OFF_RESTART_COAST 8'h0c
`define CAPM_OFF_EXT_DISPLAY   8'h10
`define CAPM_OFF_PARAM_WRITE   8'h14
`define CAPM_OFF_SCRATCH_ONE   8'h18
`define CAPM_OFF_SCRATCH_TWO   8'h1c
`define CAPM_OFF_STATUS        8'h20

`define CAPM_RST_AVG_WINDOW    16'h000a
`define CAPM_RST_MASK_INTERVAL 16'h0000
`define CAPM_RST_REF_CURRENT   16'h0064
`define CAPM_RST_RESTART_COAST 16'h270f
`define CAPM_RST_EXT_DISPLAY   16'h0000
`define CAPM_RST_PARAM_WRITE   16'h0000
`define CAPM_RST_SCRATCH       16'h270f

`define CAPM_MAX_AVG_WINDOW    16'h000a
`define CAPM_MAX_MASK_INTERVAL 16'h00c8
`define CAPM_MAX_REF_CURRENT   16'h1388
`define CAPM_MAX_SETTING       16'h270f
`define CAPM_RESTART_DISABLED  16'h270f

`define CAPM_STAT_LEVEL_BIT    7
`define CAPM_STAT_INVALID_BIT  8
`define CAPM_STAT_LOW_LSB      16
`define CAPM_STAT_MAINT_LSB    24

`define CAPM_DIV_NUM_W         26
`define CAPM_DIV_DEN_W         16

`endif

/* File: design/capm_pkg.sv */
// Types shared by the current average pulse monitor.
package capm_pkg;

  typedef enum logic [6:0] {
    CAPM_IDLE  = 7'h01,
    CAPM_MASK  = 7'h02,
    CAPM_START = 7'h04,
    CAPM_LOW   = 7'h08,
    CAPM_MAINT = 7'h10,
    CAPM_END   = 7'h20,
    CAPM_BLANK = 7'h40
  } capm_state_t;

  typedef struct packed {
    logic        const_speed;
    logic        accel_decel;
    logic        restart_active;
    logic [15:0] out_current;
  } capm_drive_t;

endpackage

/* File: design/capm_tick.sv */
// Divides the system clock down to the 0.1 s timebase pulse.
module capm_tick #(
  parameter int unsigned TICK_CYCLES = 10000000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  output logic      tick
);

  logic [31:0] count;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (ce) begin
      if (count == 32'(TICK_CYCLES - 1)) begin
        count <= 32'h00000000;
        tick  <= 1'b1;
      end else begin
        count <= count + 32'h00000001;
        tick  <= 1'b0;
      end
    end
  end

endmodule

/* File: design/capm_div.sv */
// Sequential restoring divider, one quotient bit per enabled clock.
`include "capm_params.svh"

module capm_div (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic                        start,
  input  wire logic [`CAPM_DIV_NUM_W-1:0]  num,
  input  wire logic [`CAPM_DIV_DEN_W-1:0]  den,
  output logic      [`CAPM_DIV_NUM_W-1:0]  quotient,
  output logic                             busy
);

  logic [`CAPM_DIV_DEN_W:0]   rem;
  logic [4:0]                 steps;
  logic [`CAPM_DIV_DEN_W:0]   next_rem;

  assign next_rem = {rem[`CAPM_DIV_DEN_W-1:0],
                     quotient[`CAPM_DIV_NUM_W-1]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rem      <= '0;
      quotient <= '0;
      steps    <= 5'h00;
      busy     <= 1'b0;
    end else if (ce) begin
      if (start) begin
        rem      <= '0;
        quotient <= num;
        steps    <= 5'(`CAPM_DIV_NUM_W);
        busy     <= 1'b1;
      end else if (busy) begin
        if (next_rem >= {1'b0, den}) begin
          rem      <= next_rem - {1'b0, den};
          quotient <= {quotient[`CAPM_DIV_NUM_W-2:0], 1'b1};
        end else begin
          rem      <= next_rem;
          quotient <= {quotient[`CAPM_DIV_NUM_W-2:0], 1'b0};
        end
        steps <= steps - 5'h01;
        busy  <= (steps != 5'h01);
      end
    end
  end

endmodule

/* File: tb/capm_sva.sv */
// Assertion checker for the monitor bus answers and pulse output.
`include "capm_params.svh"

module capm_sva #(
  parameter int unsigned TICK_CYCLES = 40
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        avg_current_pulse_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HI_START = `CAPM_START_TICKS * TICK_CYCLES;
  localparam int unsigned HI_MIN   = `CAPM_MAINT_MIN_TICKS * TICK_CYCLES;
  localparam int unsigned HI_MAX   = `CAPM_MAINT_MAX_TICKS * TICK_CYCLES;
  localparam int unsigned LO_MIN   = `CAPM_LOW_MIN_TICKS * TICK_CYCLES;
  localparam int unsigned PERIOD   = `CAPM_CYCLE_TICKS * TICK_CYCLES;
  logic        prev;
  logic        synced;
  logic        after_start;
  logic        seen_edge;
  logic [31:0] seg;
  logic [31:0] since_rise;
  assign seen_edge = (avg_current_pulse_out != prev);
  // Widths before the first start edge after reset are not framed.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev <= 1'b0;
      synced <= 1'b0;
      seg <= 32'h0;
      since_rise <= 32'h0;
      after_start <= 1'b0;
    end else begin
      prev <= avg_current_pulse_out;
      synced <= synced | (seen_edge & avg_current_pulse_out);
      seg <= seen_edge ? 32'h1 : seg + 32'h1;
      // Only a start rise opens a cycle; the timer rise follows a 1 s high.
      if (seen_edge & !avg_current_pulse_out) begin
        after_start <= (seg == HI_START);
      end
      since_rise <= (seen_edge & avg_current_pulse_out & !after_start)
                    ? 32'h1 : since_rise + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  property p_rdy_time;
    psel && penable && !pready |=> pready;
  endproperty
  property p_err;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `CAPM_OFF_STATUS);
  endproperty
  property p_scratch;
    pready && !pwrite && (paddr == `CAPM_OFF_SCRATCH_ONE ||
    paddr == `CAPM_OFF_SCRATCH_TWO) |-> prdata <= 32'(`CAPM_MAX_SETTING);
  endproperty
  property p_high;
    seen_edge && !avg_current_pulse_out && synced |->
      seg == HI_START || (seg >= HI_MIN && seg <= HI_MAX);
  endproperty
  property p_low;
    seen_edge && avg_current_pulse_out && synced |-> seg >= LO_MIN;
  endproperty
  property p_tick;
    seen_edge && synced |-> seg % TICK_CYCLES == 0;
  endproperty
  property p_period;
    seen_edge && avg_current_pulse_out && synced && !after_start |->
      since_rise >= PERIOD;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  a_rdy_time: assert property (p_rdy_time) else $error("ready late");
  a_err: assert property (p_err) else $error("wrong slave error");
  a_scratch: assert property (p_scratch) else $error("scratch range");
  a_high: assert property (p_high) else $error("high width");
  a_low: assert property (p_low) else $error("low width");
  a_tick: assert property (p_tick) else $error("off tick");
  a_period: assert property (p_period) else $error("short cycle");
  c_invalid: cover property (seen_edge && prev && seg == 35 * TICK_CYCLES);
  c_err: cover property (pready && pslverr);
  c_low_min: cover property (seen_edge && !prev && seg == LO_MIN);
endmodule

bind capm_top capm_sva #(.TICK_CYCLES(TICK_CYCLES)) capm_sva_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .avg_current_pulse_out(avg_current_pulse_out));

/* File: tb/capm_plc_model.sv */
// Controller input model that times each monitor pulse segment.
module capm_plc_model (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   pulse_in,
  output logic        seg_valid,
  output logic        seg_level,
  output logic [31:0] seg_clocks
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        prev;
  logic        synced;
  logic [31:0] cnt;
  // Nothing is reported until a start edge frames the cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev <= 1'b0;
      synced <= 1'b0;
      cnt <= 32'h0;
      seg_valid <= 1'b0;
      seg_level <= 1'b0;
      seg_clocks <= 32'h0;
    end else begin
      prev <= pulse_in;
      seg_valid <= 1'b0;
      cnt <= cnt + 32'h1;
      if (pulse_in != prev) begin
        seg_valid <= synced;
        seg_level <= prev;
        seg_clocks <= cnt;
        cnt <= 32'h1;
        synced <= synced | pulse_in;
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the current average pulse monitor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned T = 40;
  logic                  clk;
  logic                  rst_n;
  capm_pkg::capm_drive_t drive;
  logic [15:0]           hours;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  pulse;
  logic                  seg_valid;
  logic                  seg_level;
  logic [31:0]           seg_clocks;
  logic [32:0]           pq [$];
  logic [32:0]           rq [$];
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                          8'h1c};
  logic [15:0] rv [8] = '{16'h000a, 16'h0000, 16'h0064, 16'h270f, 16'h0000,
                          16'h0000, 16'h270f, 16'h270f};
  logic [7:0]  wa [7] = '{8'h18, 8'h1c, 8'h10, 8'h18, 8'h10, 8'h1c, 8'h04};
  logic [15:0] wd [7] = '{16'h04d2, 16'h2710, 16'h0001, 16'h0005, 16'h0000,
                          16'h0000, 16'h0003};
  logic [15:0] we [7] = '{16'h04d2, 16'h270f, 16'h0001, 16'h04d2, 16'h0000,
                          16'h0000, 16'h0003};
  int                    num_errors = 0;
  int                    checked = 0;
  int                    cycles = 0;
  int                    seed;
  int                    cur;
  int                    lw;
  int                    mw;
  capm_top #(.TICK_CYCLES(T)) capm_top_i (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .drive(drive),
    .maintenance_hours_count(hours), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .avg_current_pulse_out(pulse));
  capm_plc_model capm_plc_model_i (
    .clk(clk), .rst_n(rst_n), .pulse_in(pulse), .seg_valid(seg_valid),
    .seg_level(seg_level), .seg_clocks(seg_clocks));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    rq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic seg(input logic lvl, input int ticks);
    pq.push_back({lvl, 32'(ticks * T)});
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hung handshake or a missing edge ends here as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 70000) begin
      num_errors++;
      test_done();
    end
  end
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      check({pslverr, prdata}, rq.pop_front());
    end
    if (seg_valid === 1'b1) begin
      check({seg_level, seg_clocks}, pq.pop_front());
    end
  end
  initial begin
    seed = 83478;
    rst_n = 1'b0;
    drive = '0;
    hours = 16'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], {17'h0, rv[i]});
    end
    rd(8'h24, {1'b1, 32'h0});
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, wa[i], {16'h0, wd[i]});
      rd(wa[i], {17'h0, we[i]});
    end
    $display("register test done");
    cur = $unsigned($random(seed)) % 199 + 1;
    hours <= 16'($unsigned($random(seed)) % 800);
    lw = (cur * 50 / 100 < 5) ? 5 : (cur * 50 / 100 > 90) ? 90 : cur / 2;
    @(posedge clk);
    mw = (hours / 8 < 20) ? 20 : (hours / 8 > 90) ? 90 : hours / 8;
    // Valid, then invalid with blank, then zero current, masks of 3.
    seg(1, 10); seg(0, lw); seg(1, mw); seg(0, 190 - lw - mw);
    seg(1, 35); seg(0, 420);
    seg(1, 10); seg(0, 5); seg(1, mw);
    drive.out_current <= 16'(cur);
    drive.const_speed <= 1'b1;
    @(posedge pulse);
    @(posedge pulse);
    @(posedge pulse);
    @(posedge clk);
    repeat (5 * T + T / 2 - 1) @(posedge clk);
    drive.const_speed <= 1'b0;
    drive.accel_decel <= 1'b1;
    repeat (445 * T) @(posedge clk);
    drive.const_speed <= 1'b1;
    drive.accel_decel <= 1'b0;
    drive.out_current <= 16'h0;
    @(posedge pulse);
    cur = $unsigned($random(seed)) % 10000;
    apb(1'b1, 8'h18, 32'(cur));
    rd(8'h18, 33'(cur));
    repeat (500 * T) @(posedge clk);
    check({32'h0, pulse}, 33'h0);
    check(33'(pq.size()), 33'h0);
    // Restart enabled and active when the mask runs out: blank cycle.
    apb(1'b1, 8'h0c, 32'h5);
    drive.restart_active <= 1'b1;
    drive.accel_decel <= 1'b1;
    repeat (2 * T) @(posedge clk);
    drive.accel_decel <= 1'b0;
    repeat (8 * T) @(posedge clk);
    rd(8'h20, {2'h0, 7'(mw), 8'h05, 9'h000, 7'h40});
    check(33'(pq.size()), 33'h0);
    $display("pulse test done");
    test_done();
  end
endmodule
